// ==== sadec_top.sv ====
// Function
// (R1) External RAM region unmapped, answers error.
// (R2) External device region unmapped, answers error.
// (R3) Private region only for core controllers.
// (R4) Private region needs privileged core mode.
// (R5) Vendor system region unmapped, answers error.
// (R6) Code fetches go to cache; misses fill.
// (R7) Code-data port reaches flash and info block.
// (R8) System port reaches SRAM, AHB, APB.
// (R9) DMA reaches system targets, not private region.
// (R10) Peripheral selected; offset passed onward.
// (R11) Exactly one peripheral per window.
// (R12) Low peripheral region routed through bridge.
// (R13) Unimplemented region answers bus error.
// (R14) Refused private access errors, no write.
`timescale 1ns/1ps
`default_nettype none
module sadec_top (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst_n,
  input  wire sadec_pkg::sadec_req_s i_req,
  output logic                      o_req_ready,
  output sadec_pkg::sadec_rsp_s     o_rsp
);

  // =====================================================================
  // Range test
  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // =====================================================================
  // Peripheral window match
  logic [sadec_pkg::NUM_PERIPH-1:0] hit;

  for (genvar g = 0; g < sadec_pkg::NUM_PERIPH; g++) begin : g_win
    localparam logic [31:0] BASE = sadec_pkg::PERIPH_BASE[g];
    assign hit[g] = sadec_pkg::PERIPH_SMALL[g] ? (i_req.addr[31:10] == BASE[31:10])
                                               : (i_req.addr[31:12] == BASE[31:12]); // R11
  end

  // Windows do not overlap, so the lowest hit is the only hit.
  function automatic logic [5:0] first_hit(input logic [sadec_pkg::NUM_PERIPH-1:0] h);
    first_hit = sadec_pkg::PERIPH_NONE;
    for (int k = sadec_pkg::NUM_PERIPH - 1; k >= 0; k--) begin
      if (h[k]) begin
        first_hit = 6'(k);
      end
    end
  endfunction

  wire logic [5:0] periph_idx = first_hit(hit);
  wire logic       periph_hit = |hit;
  wire logic       periph_small = periph_hit && sadec_pkg::PERIPH_SMALL[periph_idx];
  wire logic [11:0] periph_off = periph_small ? {2'b00, i_req.addr[9:0]} : i_req.addr[11:0]; // R10

  // =====================================================================
  // Region decode
  wire logic [31:0] a         = i_req.addr;
  wire logic        r_code    = in_rng(a, sadec_pkg::CODE_LO, sadec_pkg::CODE_HI);
  wire logic        r_flash   = in_rng(a, sadec_pkg::FLASH_LO, sadec_pkg::FLASH_HI);
  wire logic        r_info    = in_rng(a, sadec_pkg::INFO_LO, sadec_pkg::INFO_HI);
  wire logic        r_sram    = in_rng(a, sadec_pkg::SRAM_LO, sadec_pkg::SRAM_HI);
  wire logic        r_apb     = in_rng(a, sadec_pkg::APB_LO, sadec_pkg::APB_HI);
  wire logic        r_ppb     = in_rng(a, sadec_pkg::PPB_LO, sadec_pkg::PPB_HI);
  wire logic        is_core   = (i_req.ctl != sadec_pkg::CTL_DMA);
  wire logic        ppb_ok    = (i_req.ctl == sadec_pkg::CTL_SYS) && i_req.priv; // R3 R4 R9

  // Peripherals above the bridged region still use the peripheral table.
  wire logic        r_periph  = periph_hit && (r_apb || a[31:29] == 3'b010); // R12

  sadec_pkg::sadec_tgt_e tgt;

  // Code space belongs to the code ports; the rest to system port and DMA.
  // Regions external RAM, external device and vendor fall to the error default.
  always_comb begin
    tgt = sadec_pkg::TGT_ERROR; // R1 R2 R5 R13
    if (i_req.ctl == sadec_pkg::CTL_ICODE) begin
      if (r_code) begin
        tgt = sadec_pkg::TGT_ICACHE; // R6
      end
    end else if (i_req.ctl == sadec_pkg::CTL_DCODE) begin
      if (r_flash) begin
        tgt = sadec_pkg::TGT_FLASH; // R7
      end else if (r_info) begin
        tgt = sadec_pkg::TGT_INFO; // R7
      end
    end else begin
      if (r_sram) begin
        tgt = sadec_pkg::TGT_SRAM; // R8 R9
      end else if (r_periph) begin
        tgt = sadec_pkg::TGT_APB; // R8 R9 R11
      end else if (r_ppb && ppb_ok) begin
        tgt = sadec_pkg::TGT_PPB; // R3 R4
      end
    end
  end

  wire logic is_err = (tgt == sadec_pkg::TGT_ERROR);

  // =====================================================================
  // Response register
  // The decoder is a single pipeline stage, so it never stalls a controller.
  assign o_req_ready = 1'b1;

  sadec_pkg::sadec_rsp_s rsp_d;
  sadec_pkg::sadec_rsp_s rsp_q;

  always_comb begin
    rsp_d.valid  = i_req.valid;
    rsp_d.target = tgt;
    rsp_d.periph = (tgt == sadec_pkg::TGT_APB) ? periph_idx : sadec_pkg::PERIPH_NONE; // R10
    rsp_d.offset = (tgt == sadec_pkg::TGT_APB) ? periph_off : sadec_pkg::OFFSET_RST; // R10
    rsp_d.addr   = i_req.addr;
    rsp_d.write  = i_req.write && !is_err; // R14
    rsp_d.err    = i_req.valid && is_err; // R13 R14
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign o_rsp = rsp_q;

  // =====================================================================
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_xram_err_resp: assert property ( // R1
    $past(i_req.valid) && in_rng($past(i_req.addr), sadec_pkg::XRAM_LO, sadec_pkg::XRAM_HI) |-> o_rsp.err)
    else $error("External RAM access not refused.");

  a_xdev_err_resp: assert property ( // R2
    $past(i_req.valid) && in_rng($past(i_req.addr), sadec_pkg::XDEV_LO, sadec_pkg::XDEV_HI) |-> o_rsp.err)
    else $error("External device access not refused.");

  a_dma_ppb_refused: assert property ( // R3
    i_req.valid && i_req.ctl == sadec_pkg::CTL_DMA && in_rng(i_req.addr, sadec_pkg::PPB_LO, sadec_pkg::PPB_HI)
    |=> o_rsp.err && !o_rsp.write)
    else $error("DMA reached the private region.");

  a_ppb_priv_only: assert property ( // R4
    o_rsp.valid && o_rsp.target == sadec_pkg::TGT_PPB |-> $past(i_req.priv) && $past(is_core))
    else $error("Private region granted without privilege.");

  a_vend_err_resp: assert property ( // R5
    $past(i_req.valid) && in_rng($past(i_req.addr), sadec_pkg::VEND_LO, sadec_pkg::VEND_HI) |-> o_rsp.err)
    else $error("Vendor region access not refused.");

  a_icode_to_cache: assert property ( // R6
    i_req.valid && i_req.ctl == sadec_pkg::CTL_ICODE && r_code |=> o_rsp.target == sadec_pkg::TGT_ICACHE)
    else $error("Code fetch not sent to the cache.");

  a_dcode_flash_info: assert property ( // R7
    i_req.valid && i_req.ctl == sadec_pkg::CTL_DCODE && (r_flash || r_info) |=> !o_rsp.err)
    else $error("Code-data access to flash refused.");

  a_sys_sram_route: assert property ( // R8
    i_req.valid && i_req.ctl[1] && r_sram |=> o_rsp.target == sadec_pkg::TGT_SRAM)
    else $error("SRAM access misrouted.");

  a_periph_offset: assert property ( // R10
    o_rsp.valid && o_rsp.target == sadec_pkg::TGT_APB
    |-> o_rsp.offset[9:0] == o_rsp.addr[9:0] && o_rsp.periph != sadec_pkg::PERIPH_NONE)
    else $error("Peripheral offset or select wrong.");

  a_one_periph: assert property ( // R11
    i_req.valid |-> $onehot0(hit))
    else $error("Overlapping peripheral windows.");

  a_err_no_write: assert property ( // R14
    o_rsp.err |-> !o_rsp.write && o_rsp.target == sadec_pkg::TGT_ERROR)
    else $error("Refused access carried a write.");

endmodule // sadec_top
`default_nettype wire

// ==== sadec_pkg.sv ====
`default_nettype none
package sadec_pkg;

  // =====================================================================
  // Address regions
  localparam logic [31:0] CODE_LO   = 32'h0000_0000;
  localparam logic [31:0] CODE_HI   = 32'h1FFF_FFFF;
  localparam logic [31:0] FLASH_LO  = 32'h1000_0000;
  localparam logic [31:0] FLASH_HI  = 32'h1005_FFFF;
  localparam logic [31:0] INFO_LO   = 32'h1080_0000;
  localparam logic [31:0] INFO_HI   = 32'h1080_3FFF;
  localparam logic [31:0] SRAM_LO   = 32'h2000_0000;
  localparam logic [31:0] SRAM_HI   = 32'h2002_7FFF;
  localparam logic [31:0] APB_LO    = 32'h4000_0000;
  localparam logic [31:0] APB_HI    = 32'h400F_FFFF;
  localparam logic [31:0] XRAM_LO   = 32'h6000_0000;
  localparam logic [31:0] XRAM_HI   = 32'h9FFF_FFFF;
  localparam logic [31:0] XDEV_LO   = 32'hA000_0000;
  localparam logic [31:0] XDEV_HI   = 32'hDFFF_FFFF;
  localparam logic [31:0] PPB_LO    = 32'hE000_0000;
  localparam logic [31:0] PPB_HI    = 32'hE00F_FFFF;
  localparam logic [31:0] VEND_LO   = 32'hE010_0000;
  localparam logic [31:0] VEND_HI   = 32'hFFFF_FFFF;

  // =====================================================================
  // Peripheral windows
  localparam int          NUM_PERIPH = 34;
  localparam logic [31:0] PERIPH_BASE [NUM_PERIPH] = '{
    32'h4000_0000, 32'h4000_0400, 32'h4000_0800, 32'h4000_3000, 32'h4000_3400,
    32'h4000_5000, 32'h4000_7400, 32'h4000_8000, 32'h4000_9000, 32'h4000_F000,
    32'h4001_0000, 32'h4001_1000, 32'h4001_2000, 32'h4001_3000, 32'h4001_D000,
    32'h4001_E000, 32'h4001_F000, 32'h4002_8000, 32'h4002_9000, 32'h4002_A000,
    32'h4004_2000, 32'h4004_3000, 32'h4004_4000, 32'h4004_6000, 32'h4004_7000,
    32'h4004_8000, 32'h4004_D000, 32'h4006_0000, 32'h4010_6000, 32'h4010_6800,
    32'h4010_6C00, 32'h4011_4000, 32'h4011_5000, 32'h4014_5000};
  // A set bit marks a 1KB window; a clear bit a 4KB window. Bit n is entry n.
  // Entries 0 to 6, 18, 19 and 28 to 30 are the 1KB windows.
  localparam logic [NUM_PERIPH-1:0] PERIPH_SMALL = 34'h0_700C_007F;
  localparam logic [5:0]  PERIPH_NONE = 6'h3F;
  localparam logic [11:0] OFFSET_RST  = 12'h000;

  // =====================================================================
  // Types
  typedef enum logic [1:0] {
    CTL_ICODE = 2'b00,
    CTL_DCODE = 2'b01,
    CTL_SYS   = 2'b10,
    CTL_DMA   = 2'b11
  } sadec_ctl_e;

  typedef enum logic [2:0] {
    TGT_ERROR = 3'b000,
    TGT_ICACHE = 3'b001,
    TGT_FLASH = 3'b010,
    TGT_INFO  = 3'b011,
    TGT_SRAM  = 3'b100,
    TGT_APB   = 3'b101,
    TGT_PPB   = 3'b110
  } sadec_tgt_e;

  typedef struct packed {
    logic        valid;
    sadec_ctl_e  ctl;
    logic [31:0] addr;
    logic        write;
    logic        priv;
  } sadec_req_s;

  typedef struct packed {
    logic        valid;
    sadec_tgt_e  target;
    logic [5:0]  periph;
    logic [11:0] offset;
    logic [31:0] addr;
    logic        write;
    logic        err;
  } sadec_rsp_s;

endpackage
`default_nettype wire

// ==== sadec_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Bus controller model standing in for the core ports and the DMA.
module sadec_bus_model (
  input  wire logic                  i_core_clk,
  output var sadec_pkg::sadec_req_s o_req
);
  initial o_req = '0;
  // A released bus keeps the controller and shows inverted address, write and privilege fields, so a stale request can never match by chance.
  task automatic issue(input sadec_pkg::sadec_ctl_e c, input logic [31:0] a, input logic w, input logic p);
    o_req = '{valid: 1'b1, ctl: c, addr: a, write: w, priv: p};
    @(posedge i_core_clk);
    #1 o_req = '{valid: 1'b0, ctl: c, addr: ~a, write: ~w, priv: ~p};
  endtask
endmodule // sadec_bus_model
`default_nettype wire

// ==== system_address_decoder_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module system_address_decoder_test;
  // =====================================================================
  // Clock, reset and the decoder.
  logic                  i_core_clk;
  logic                  i_rst_n;
  logic                  rdy;
  sadec_pkg::sadec_req_s req;
  sadec_pkg::sadec_rsp_s rsp;
  int                    fails;
  int                    checks_done;
  localparam sadec_pkg::sadec_ctl_e IC = sadec_pkg::CTL_ICODE;
  localparam sadec_pkg::sadec_ctl_e DC = sadec_pkg::CTL_DCODE;
  localparam sadec_pkg::sadec_ctl_e SY = sadec_pkg::CTL_SYS;
  localparam sadec_pkg::sadec_ctl_e DM = sadec_pkg::CTL_DMA;
  always #5 i_core_clk = ~i_core_clk;
  sadec_bus_model bus (.i_core_clk(i_core_clk), .o_req(req));
  sadec_top dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_req(req), .o_req_ready(rdy), .o_rsp(rsp));
  // =====================================================================
  // Shared checks.
  task automatic finish_test();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [56:0] g, input logic [56:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Waits are bounded, so a silent decoder ends the run instead of hanging it.
  task automatic chk(input sadec_pkg::sadec_ctl_e c, input logic [31:0] a, input logic w, input logic p,
                     input sadec_pkg::sadec_tgt_e t, input logic [5:0] pi, input logic [11:0] of);
    logic e;
    int   n;
    e = (t == sadec_pkg::TGT_ERROR);
    bus.issue(c, a, w, p);
    n = 0;
    while (rsp.valid !== 1'b1 && n < 3) begin
      @(posedge i_core_clk);
      #1 n++;
    end
    if (rsp.valid !== 1'b1) begin
      fails++;
      finish_test();
    end
    cmp({rsp, rdy}, {1'b1, t, pi, of, a, w & ~e, e, 1'b1});
    @(posedge i_core_clk);
    #1;
  endtask
  task automatic err(input sadec_pkg::sadec_ctl_e c, input logic [31:0] a, input logic w, input logic p);
    chk(c, a, w, p, sadec_pkg::TGT_ERROR, sadec_pkg::PERIPH_NONE, 12'h000);
  endtask
  task automatic hit(input sadec_pkg::sadec_ctl_e c, input logic [31:0] a, input logic w, input logic p,
                     input sadec_pkg::sadec_tgt_e t);
    chk(c, a, w, p, t, sadec_pkg::PERIPH_NONE, 12'h000);
  endtask
  // =====================================================================
  // Scenarios.
  task automatic t_unmapped();
    logic [31:0] al [6] = '{32'h6000_0000, 32'h9FFF_FFFC, 32'hA000_0000, 32'hDFFF_FFFC, 32'hE010_0000, 32'hFFFF_FFFC};
    foreach (al[i]) begin
      err(SY, al[i], 1'b1, 1'b1);
      err(DM, al[i], 1'b1, 1'b0);
    end
  endtask
  task automatic t_private();
    hit(SY, 32'hE000_0000, 1'b1, 1'b1, sadec_pkg::TGT_PPB);
    hit(SY, 32'hE00F_FFFC, 1'b0, 1'b1, sadec_pkg::TGT_PPB);
    err(SY, 32'hE000_E010, 1'b1, 1'b0);
    err(DM, 32'hE000_0000, 1'b1, 1'b1);
    err(DC, 32'hE000_0000, 1'b0, 1'b1);
  endtask
  task automatic t_code();
    hit(IC, 32'h0000_0000, 1'b0, 1'b1, sadec_pkg::TGT_ICACHE);
    hit(IC, 32'h1FFF_FFFC, 1'b0, 1'b1, sadec_pkg::TGT_ICACHE);
    err(IC, 32'h2000_0000, 1'b0, 1'b1);
    hit(DC, 32'h1000_0000, 1'b0, 1'b1, sadec_pkg::TGT_FLASH);
    hit(DC, 32'h1005_FFFC, 1'b0, 1'b1, sadec_pkg::TGT_FLASH);
    hit(DC, 32'h1080_3FFC, 1'b0, 1'b1, sadec_pkg::TGT_INFO);
    err(DC, 32'h1006_0000, 1'b0, 1'b1);
  endtask
  task automatic t_system();
    hit(SY, 32'h2000_0000, 1'b1, 1'b0, sadec_pkg::TGT_SRAM);
    hit(DM, 32'h2002_7FFC, 1'b1, 1'b0, sadec_pkg::TGT_SRAM);
    err(SY, 32'h2002_8000, 1'b1, 1'b0);
    chk(SY, 32'h4000_0004, 1'b1, 1'b0, sadec_pkg::TGT_APB, 6'h00, 12'h004);
    chk(DM, 32'h4014_5FFC, 1'b0, 1'b0, sadec_pkg::TGT_APB, 6'h21, 12'hFFC);
    chk(SY, 32'h4002_A3FC, 1'b1, 1'b1, sadec_pkg::TGT_APB, 6'h13, 12'h3FC);
    chk(DM, 32'h4001_0008, 1'b0, 1'b0, sadec_pkg::TGT_APB, 6'h0A, 12'h008);
    err(SY, 32'h4002_A400, 1'b1, 1'b1);
    chk(SY, 32'h4011_4400, 1'b1, 1'b1, sadec_pkg::TGT_APB, 6'h1F, 12'h400);
    chk(DM, 32'h4010_6BFC, 1'b0, 1'b0, sadec_pkg::TGT_APB, 6'h1D, 12'h3FC);
    err(SY, 32'h4010_6400, 1'b0, 1'b1);
  endtask
  // =====================================================================
  // Main sequence.
  initial begin
    i_core_clk = 1'b0;
    i_rst_n = 1'b0;
    fails = 0;
    checks_done = 0;
    repeat (20) @(posedge i_core_clk);
    #1 cmp({rsp, rdy}, {56'h0, 1'b1});
    i_rst_n = 1'b1;
    t_unmapped();
    t_private();
    t_code();
    t_system();
    finish_test();
  end
endmodule // system_address_decoder_test
`default_nettype wire
